// file: rtl/gpp_map.svh
// register map, field positions and reset values of the pin port
// assumes apb word addressing: byte address is index times four
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define GPP_IDX_DIR    6'h00
`define GPP_IDX_LEVEL  6'h04
`define GPP_IDX_CLR    6'h06
`define GPP_IDX_FLIP   6'h07
`define GPP_IDX_SAMPLE 6'h08
`define GPP_IDX_FLAGS  6'h09
`define GPP_IDX_CTRL   6'h10
// ----------------------------------------
// per pad control fields
// ----------------------------------------
`define GPP_POL_BIT    7
`define GPP_PULL_BIT   3
`define GPP_SENSE_HI   2
`define GPP_SENSE_LO   0
`define GPP_CTRL_MASK  8'h8F
// ----------------------------------------
// reset values
// ----------------------------------------
`define GPP_RST_BYTE   8'h00
`define GPP_RST_WORD   32'h0000_0000
`endif

// file: rtl/gpp_pkg.sv
// types shared by the pin port
// assumes gpp_map.svh is on the include path
package gpp_pkg;
    // ----------------------------------------
    // sense modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        GPP_SENSE_NONE = 3'h0,
        GPP_SENSE_ANY  = 3'h1,
        GPP_SENSE_RISE = 3'h2,
        GPP_SENSE_FALL = 3'h3,
        GPP_SENSE_OFF  = 3'h4,
        GPP_SENSE_LOW  = 3'h5
    } gpp_sense_type;
    // ----------------------------------------
    // apb request from the master
    // ----------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } gpp_apb_req_type;
    // ----------------------------------------
    // apb answer to the master
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gpp_apb_rsp_type;
    // ----------------------------------------
    // pad drive group
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
        logic [7:0] pull;
    } gpp_pad_type;
endpackage

// file: rtl/gpp_port.sv
// eight pin port with apb register slave
// assumes pad inputs synchronous-ish, sampled through two flops
//
// Functional notes
// RL1 - clear strobe one bits clear drive level
// RL2 - zero strobe bits leave level unchanged
// RL3 - strobe registers read back drive level
// RL4 - flip strobe or sample write toggles level
// RL5 - enabled buffer: sample bit shows pin level
// RL6 - disabled buffer holds last sample bit
// RL7 - event flag set on sense match
// RL8 - write one clears flag, zero keeps
// RL9 - polarity flip inverts input and output
// RL10 - pull-up only while pin input-only
// RL11 - sense 0: buffer on, no event
// RL12 - sense 1: event on both edges
// RL13 - sense 2: event on rising edge
// RL14 - sense 3: event on falling edge
// RL15 - sense 4: buffer and event off
// RL16 - sense 5: event on low level
// RL17 - driver enable one drives, zero releases
// RL18 - level affects pin only when driven
// RL19 - sense 6,7: buffer on, no event
// RL20 - two flop synchroniser before sampling
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "gpp_map.svh"

module gpp_port
    import gpp_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire gpp_apb_req_type apb_req_in,
    output gpp_apb_rsp_type      apb_rsp_out,
    input  wire logic [7:0]      pad_in,
    output gpp_pad_type          pad_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]      dir_reg;
    logic [7:0]      level_reg;
    logic [7:0]      sample_reg;
    logic [7:0]      flags_reg;
    logic [7:0]      ctrl_reg [8];
    logic [7:0]      sync1_reg;
    logic [7:0]      sync2_reg;
    logic            pready_reg;
    logic [31:0]     prdata_reg;
    logic            pslverr_reg;
    gpp_pad_type     pad_reg;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic [5:0]      idx;
    logic            rd_phase;
    logic            acc;
    logic            wr;
    logic            is_ctrl;
    logic            mapped;
    logic [7:0]      wbyte;
    logic [7:0]      rd_mux;

    assign idx      = apb_req_in.paddr[7:2];
    assign rd_phase = apb_req_in.psel & apb_req_in.penable & ~pready_reg;
    assign acc      = apb_req_in.psel & apb_req_in.penable & pready_reg;
    assign wr       = acc & apb_req_in.pwrite;
    assign wbyte    = apb_req_in.pwdata[7:0];
    assign is_ctrl  = (idx[5:3] == `GPP_IDX_CTRL >> 3) & (apb_req_in.paddr[1:0] == 2'h0);

    always_comb begin
        mapped = 1'b1;
        rd_mux = `GPP_RST_BYTE;
        if (is_ctrl) begin
            rd_mux = ctrl_reg[idx[2:0]];
        end else if (apb_req_in.paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else begin
            unique case (idx)
                `GPP_IDX_DIR:    rd_mux = dir_reg;
                `GPP_IDX_LEVEL:  rd_mux = level_reg;
                `GPP_IDX_CLR:    rd_mux = level_reg; // RL3
                `GPP_IDX_FLIP:   rd_mux = level_reg; // RL3
                `GPP_IDX_SAMPLE: rd_mux = sample_reg;
                `GPP_IDX_FLAGS:  rd_mux = flags_reg;
                default:         mapped = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // apb answer, one wait state
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= rd_phase;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_reg  <= `GPP_RST_WORD;
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= rd_phase & ~mapped;
            if (rd_phase & ~apb_req_in.pwrite) begin
                prdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

    assign apb_rsp_out = '{prdata: prdata_reg, pready: pready_reg, pslverr: pslverr_reg};

    // ----------------------------------------
    // direction and drive level
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dir_reg <= `GPP_RST_BYTE;
        end else if (wr & ~is_ctrl & (idx == `GPP_IDX_DIR)) begin
            dir_reg <= wbyte;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_reg <= `GPP_RST_BYTE;
        end else if (wr & ~is_ctrl) begin
            unique case (idx)
                `GPP_IDX_LEVEL:  level_reg <= wbyte;
                `GPP_IDX_CLR:    level_reg <= level_reg & ~wbyte; // RL1 RL2
                `GPP_IDX_FLIP:   level_reg <= level_reg ^ wbyte; // RL4 RL2
                `GPP_IDX_SAMPLE: level_reg <= level_reg ^ wbyte; // RL4
                default:         level_reg <= level_reg;
            endcase
        end
    end

    // ----------------------------------------
    // per pad control
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                ctrl_reg[i] <= `GPP_RST_BYTE;
            end
        end else if (wr & is_ctrl) begin
            ctrl_reg[idx[2:0]] <= wbyte & `GPP_CTRL_MASK;
        end
    end

    // ----------------------------------------
    // input sampling
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_reg <= `GPP_RST_BYTE;
            sync2_reg <= `GPP_RST_BYTE;
        end else begin
            sync1_reg <= pad_in; // RL20
            sync2_reg <= sync1_reg; // RL20
        end
    end

    logic [7:0] pol;
    logic [7:0] buf_en;
    logic [7:0] smp;
    logic [7:0] hit;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gpp_sense_type s;
            s         = gpp_sense_type'(ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO]);
            pol[i]    = ctrl_reg[i][`GPP_POL_BIT];
            buf_en[i] = (s != GPP_SENSE_OFF); // RL15 RL19
            smp[i]    = sync2_reg[i] ^ pol[i]; // RL9
            hit[i]    = 1'b0;
            if (buf_en[i]) begin
                case (s)
                    GPP_SENSE_ANY:  hit[i] = smp[i] ^ sample_reg[i]; // RL12
                    GPP_SENSE_RISE: hit[i] = smp[i] & ~sample_reg[i]; // RL13
                    GPP_SENSE_FALL: hit[i] = ~smp[i] & sample_reg[i]; // RL14
                    GPP_SENSE_LOW:  hit[i] = ~smp[i]; // RL16
                    default:        hit[i] = 1'b0; // RL11 RL19
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sample_reg <= `GPP_RST_BYTE;
        end else begin
            sample_reg <= (smp & buf_en) | (sample_reg & ~buf_en); // RL5 RL6
        end
    end

    // ----------------------------------------
    // event flags, set wins over clear
    // ----------------------------------------
    logic [7:0] flag_clr;
    assign flag_clr = (wr & ~is_ctrl & (idx == `GPP_IDX_FLAGS)) ? wbyte : 8'h00;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_reg <= `GPP_RST_BYTE;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | hit; // RL7 RL8
        end
    end

    // ----------------------------------------
    // pad drive
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pad_reg <= '0;
        end else begin
            pad_reg.oe    <= dir_reg; // RL17
            pad_reg.level <= (level_reg ^ pol) & dir_reg; // RL9 RL18
            for (int i = 0; i < 8; i++) begin
                pad_reg.pull[i] <= ctrl_reg[i][`GPP_PULL_BIT] & ~dir_reg[i]; // RL10
            end
        end
    end

    assign pad_out = pad_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic wr_clr;
    logic wr_flip;
    assign wr_clr  = wr & ~is_ctrl & (idx == `GPP_IDX_CLR);
    assign wr_flip = wr & ~is_ctrl & ((idx == `GPP_IDX_FLIP) | (idx == `GPP_IDX_SAMPLE));

    AST_CLR_LOW: assert property (wr_clr |=> (level_reg & $past(wbyte)) == 8'h00) // RL1
        else $error("clear strobe left a level bit high");

    AST_ZERO_KEEP: assert property ((wr_clr | wr_flip)
        |=> (level_reg & ~$past(wbyte)) == ($past(level_reg) & ~$past(wbyte))) // RL2
        else $error("zero strobe bit changed level");

    AST_READBACK: assert property ((rd_phase & ~apb_req_in.pwrite & ~is_ctrl
        & ((idx == `GPP_IDX_CLR) | (idx == `GPP_IDX_FLIP)) & (apb_req_in.paddr[1:0] == 2'h0))
        |=> pready_reg && prdata_reg[7:0] == $past(level_reg)) // RL3
        else $error("strobe read did not return level");

    AST_FLIP: assert property (wr_flip |=> level_reg == ($past(level_reg) ^ $past(wbyte))) // RL4
        else $error("flip did not invert level");

    AST_SAMPLE: assert property (##1 (sample_reg & $past(buf_en))
        == ($past(sync2_reg ^ pol) & $past(buf_en))) // RL5
        else $error("enabled sample bit wrong");

    AST_HOLD: assert property (##1 (sample_reg & ~$past(buf_en))
        == ($past(sample_reg) & ~$past(buf_en))) // RL6
        else $error("disabled sample bit changed");

    AST_EVENT: assert property (hit != 8'h00 |=> (flags_reg & $past(hit)) == $past(hit)) // RL7
        else $error("event flag not set");

    AST_W1C: assert property ((flag_clr != 8'h00) && (hit == 8'h00)
        |=> (flags_reg & $past(flag_clr)) == 8'h00) // RL8
        else $error("flag not cleared by write one");

    AST_DRIVE: assert property (##2 pad_out.oe == $past(dir_reg, 1)
        && pad_out.level == ($past(level_reg ^ pol) & $past(dir_reg))) // RL17
        else $error("pad drive mismatch");

    AST_PULL: assert property ((pad_out.pull & pad_out.oe) == 8'h00) // RL10
        else $error("pull-up on a driven pin");

    // ----------------------------------------
    // sense decode for checks
    // ----------------------------------------
    logic [7:0] chk_none;
    logic [7:0] chk_any;
    logic [7:0] chk_rise;
    logic [7:0] chk_fall;
    logic [7:0] chk_off;
    logic [7:0] chk_low;
    logic [7:0] chk_rsvd;
    logic [7:0] chk_pull;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            chk_none[i] = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_NONE);
            chk_any[i]  = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_ANY);
            chk_rise[i] = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_RISE);
            chk_fall[i] = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_FALL);
            chk_off[i]  = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_OFF);
            chk_low[i]  = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] == GPP_SENSE_LOW);
            chk_rsvd[i] = (ctrl_reg[i][`GPP_SENSE_HI:`GPP_SENSE_LO] >= 3'h6);
            chk_pull[i] = ctrl_reg[i][`GPP_PULL_BIT] & ~dir_reg[i];
        end
    end

    // ----------------------------------------
    // sense mode checks
    // ----------------------------------------
    AST_NONE_QUIET: assert property (((hit & chk_none) == 8'h00) // RL11
        && ((buf_en & chk_none) == chk_none))
        else $error("sense none raised an event");

    AST_ANY_EDGE: assert property (##1 ((sample_reg ^ $past(sample_reg)) // RL12
        & $past(chk_any) & ~flags_reg) == 8'h00)
        else $error("edge missed in any-edge mode");

    AST_RISE_EDGE: assert property (##1 ((sample_reg & ~$past(sample_reg)) // RL13
        & $past(chk_rise) & ~flags_reg) == 8'h00)
        else $error("rising edge missed");

    AST_RISE_ONLY: assert property (##1 ((~sample_reg & $past(sample_reg)) // RL13
        & $past(chk_rise) & flags_reg & ~$past(flags_reg)) == 8'h00)
        else $error("falling edge set flag in rise mode");

    AST_FALL_EDGE: assert property (##1 ((~sample_reg & $past(sample_reg)) // RL14
        & $past(chk_fall) & ~flags_reg) == 8'h00)
        else $error("falling edge missed");

    AST_FALL_ONLY: assert property (##1 ((sample_reg & ~$past(sample_reg)) // RL14
        & $past(chk_fall) & flags_reg & ~$past(flags_reg)) == 8'h00)
        else $error("rising edge set flag in fall mode");

    AST_OFF_QUIET: assert property (((hit & chk_off) == 8'h00) // RL15
        && ((buf_en & chk_off) == 8'h00))
        else $error("disabled buffer still active");

    AST_OFF_HOLD: assert property (##1 ((sample_reg ^ $past(sample_reg)) // RL15
        & $past(chk_off)) == 8'h00)
        else $error("disabled pin sample changed");

    AST_LOW_SET: assert property (##1 (~sample_reg & $past(chk_low) // RL16
        & ~flags_reg) == 8'h00)
        else $error("low level did not set flag");

    AST_RSVD_QUIET: assert property (((hit & chk_rsvd) == 8'h00) // RL19
        && ((buf_en & chk_rsvd) == chk_rsvd))
        else $error("reserved sense raised an event");

    // ----------------------------------------
    // synchroniser, pull-up and bus checks
    // ----------------------------------------
    AST_SYNC: assert property (##2 sync2_reg == $past(pad_in, 2)) // RL20
        else $error("synchroniser delay wrong");

    AST_PULL_ON: assert property (##1 pad_out.pull == $past(chk_pull)) // RL10
        else $error("pull-up not following control");

    AST_PREADY_ONE: assert property (pready_reg |=> !pready_reg)
        else $error("ready held longer than one cycle");

    AST_ERR_READY: assert property (pslverr_reg |-> pready_reg)
        else $error("error without ready");

    AST_RDATA_HIGH: assert property (prdata_reg[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    COV_FLIP:  cover property (wr_flip ##1 wr_clr);
    COV_EVENT: cover property (hit != 8'h00 ##1 flag_clr != 8'h00);
    COV_ERR:   cover property (pslverr_reg);
    COV_LOW:   cover property ((hit & chk_low) != 8'h00);
    COV_OFF:   cover property ((chk_off != 8'h00) ##1 (chk_off == 8'h00));

endmodule

// file: tb/gpp_pins.sv
// far side: pads, each with an outside source behind it
// assumes the port drives pad_in and the bench sets ext_in
`timescale 1ns/1ns
module gpp_pins
    import gpp_pkg::*;
(
    input  wire gpp_pad_type pad_in,
    input  wire logic [7:0]  ext_in,
    output logic [7:0]       pin_out
);
    // ----------------------------------------
    // pad level: driver, else pull-up, else outside
    // ----------------------------------------
    assign pin_out = (pad_in.oe & pad_in.level) |
                     (~pad_in.oe & pad_in.pull) |
                     (~pad_in.oe & ~pad_in.pull & ext_in);
endmodule

// file: tb/gpp_port_pin_control_bench.sv
// self-checking bench of the pin port
// assumes gpp_map.svh on the include path, apb with one wait state
`timescale 1ns/1ns
`include "gpp_map.svh"
module gpp_port_pin_control_bench;
    import gpp_pkg::*;
    logic            clk_in;
    logic            rst_in;
    gpp_apb_req_type apb_req;
    gpp_apb_rsp_type apb_rsp;
    gpp_pad_type     pad;
    logic [7:0]      ext;
    logic [7:0]      pin;
    logic [31:0]     rd;
    logic            err;
    logic [15:0]     seed;
    logic [7:0]      lvl;
    int              failures = 0;
    int              comparisons = 0;
    int              cycles = 0;
    gpp_port gpp_port_i (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .apb_req_in  (apb_req),
        .apb_rsp_out (apb_rsp),
        .pad_in      (pin),
        .pad_out     (pad)
    );
    gpp_pins gpp_pins_i (
        .pad_in  (pad),
        .ext_in  (ext),
        .pin_out (pin)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge clk_in);
        apb_req <= {1'b1, 1'b0, wr, idx, 2'h0, 24'h0, wd};
        @(posedge clk_in);
        apb_req.penable <= 1'b1;
        do @(posedge clk_in); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_in = 1'b1;
        apb_req = '0;
        ext = 8'h00;
        seed = 16'hAFCF;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 6; i < 10; i++) rdchk(i[5:0], 32'h0);
        rdchk(`GPP_IDX_CTRL, 32'h0);
        chk({8'h0, pad}, 32'h0);
        apb(1'b1, `GPP_IDX_DIR, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            lvl = seed[7:0];
            apb(1'b1, `GPP_IDX_LEVEL, lvl);
            seed = lfsr(seed);
            apb(1'b1, `GPP_IDX_CLR, seed[7:0]);
            lvl = lvl & ~seed[7:0];
            rdchk(`GPP_IDX_CLR, {24'h0, lvl});
            seed = lfsr(seed);
            apb(1'b1, `GPP_IDX_FLIP, seed[7:0]);
            lvl = lvl ^ seed[7:0];
            seed = lfsr(seed);
            apb(1'b1, `GPP_IDX_SAMPLE, seed[7:0]);
            lvl = lvl ^ seed[7:0];
            rdchk(`GPP_IDX_FLIP, {24'h0, lvl});
            chk({24'h0, pad.level}, {24'h0, lvl});
        end
        apb(1'b1, `GPP_IDX_CTRL, 8'h80);
        repeat (2) @(posedge clk_in);
        chk({24'h0, pad.level}, {24'h0, lvl ^ 8'h01});
        rdchk(`GPP_IDX_SAMPLE, {24'h0, lvl});
        apb(1'b1, `GPP_IDX_CTRL, 8'h00);
        apb(1'b1, `GPP_IDX_CTRL + 6'h01, 8'h08);
        apb(1'b1, `GPP_IDX_DIR, 8'h02);
        repeat (2) @(posedge clk_in);
        chk({24'h0, pad.pull}, 32'h0);
        apb(1'b1, `GPP_IDX_DIR, 8'h00);
        seed = lfsr(seed);
        ext <= seed[7:0];
        repeat (2) @(posedge clk_in);
        chk({8'h0, pad}, 32'h0000_0002);
        rdchk(`GPP_IDX_SAMPLE, {24'h0, seed[7:0] | 8'h02});
        for (int m = 0; m < 8; m++) begin
            ext <= 8'h04;
            apb(1'b1, `GPP_IDX_CTRL + 6'h02, m[7:0]);
            apb(1'b1, `GPP_IDX_FLAGS, 8'hFF);
            ext <= 8'h00;
            repeat (4) @(posedge clk_in);
            apb(1'b1, `GPP_IDX_FLAGS, 8'h00);
            rdchk(`GPP_IDX_FLAGS, (m == 1 || m == 3 || m == 5) ? 4 : 0);
            rdchk(`GPP_IDX_SAMPLE, (m == 4) ? 6 : 2);
            apb(1'b1, `GPP_IDX_FLAGS, 8'hFF);
            ext <= 8'h04;
            repeat (4) @(posedge clk_in);
            rdchk(`GPP_IDX_FLAGS, (m == 1 || m == 2 || m == 5) ? 4 : 0);
        end
        apb(1'b1, 6'h0A, 8'hFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 6'h3F, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        tally_and_finish;
    end
endmodule
